// File: design/swmp_monitor_port.sv
// Behaviour
// - clock strap low bypasses divide-by-two
// - enter by software interrupt or reset
// - eight security bytes, then ready break
// - monitor uses vector page fe
// - watchdog off in monitor mode while high voltage present
// - nrz mark/space asynchronous bytes
// - rate 4800 or 9600, equal directions
// - wired-or pin, only pull low
// - echo every received byte immediately
// - results only after last echo
// - break is start plus nine lows
// - break answered by two high bits
// - six commands supported
// - commands reach whole address map
// - indexed read returns next two bytes
// - other pins keep normal function
// - indexed write stores at last plus one
// - run command executes return from interrupt
// - strap high 4800 baud, low 9600
// - flash reads invalid unless security matches
module swmp_monitor_port #(
   parameter int          BitCyclesSlow = swmp_pkg::BIT_CYCLES_SLOW,
   parameter int          BitCyclesFast = swmp_pkg::BIT_CYCLES_FAST,
   parameter logic [15:0] FlashBase     = swmp_pkg::FLASH_BASE
) (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // monitor serial pin, open drain
   input  wire logic                    serialIn,
   output logic                         serialOut,
   output logic                         serialOe,
   // entry straps and high-voltage sense
   input  wire swmp_pkg::swmp_straps_t  straps,
   // cpu side
   input  wire logic                    swiExec,
   input  wire logic [15:0]             stackPointer,
   input  wire logic [63:0]             securityCode,
   // memory port
   output swmp_pkg::swmp_mem_req_t      memReq,
   input  wire logic [7:0]              memRdata,
   // mode outputs
   output logic                         monitorMode,
   output logic                         clockBypass,
   output logic                         baudFast,
   output logic                         watchdogEnable,
   output logic [15:0]                  resetVector,
   output logic [15:0]                  swiVector,
   output logic                         flashUnlocked,
   output logic                         runUser
);

   swmp_pkg::swmp_regs_t r;
   swmp_pkg::swmp_regs_t next_r;

   function automatic logic [15:0] bitCycles(input logic fast);
      return fast ? 16'(BitCyclesFast - 1) : 16'(BitCyclesSlow - 1);
   endfunction

   always_comb begin
      logic [15:0] bitCyc;
      logic [7:0]  respByte;
      next_r = r;
      bitCyc = bitCycles(r.clockBypass);
      respByte = 8'h00;
      // synchronisers
      next_r.pinSync1 = serialIn;
      next_r.pinSync2 = r.pinSync1;
      next_r.pinPrev = r.pinSync2;
      next_r.strapSync1 = straps;
      next_r.strapSync2 = r.strapSync1;
      next_r.runUser = 1'b0;
      next_r.mem.req = 1'b0;
      next_r.mem.we = 1'b0;

      // strap capture after reset release
      if (!r.captured) begin
         if (r.settle == swmp_pkg::SETTLE_LAST) begin
            next_r.captured = 1'b1;
            next_r.monitor = r.strapSync2.irqHighVolt && r.strapSync2.entryStrapHigh
                             && !r.strapSync2.entryStrapLow && r.pinSync2;
            next_r.clockBypass = next_r.monitor && !r.strapSync2.clockSelectStrap;
            next_r.secMatch = 1'b1;
            if (next_r.monitor) begin
               next_r.st = swmp_pkg::ST_IDLE;
            end
         end else begin
            next_r.settle = r.settle + 2'h1;
         end
      end else if (swiExec && !r.monitor) begin
         next_r.monitor = 1'b1;
         next_r.secMatch = r.secDone && r.secMatch;
         next_r.secDone = 1'b1;
         next_r.st = swmp_pkg::ST_IDLE;
      end

      next_r.watchdogEnable = !(next_r.monitor
         && (r.strapSync2.irqHighVolt || r.strapSync2.rstHighVolt));
      next_r.resetVector = next_r.monitor ? swmp_pkg::MON_RESET_VEC
                                          : swmp_pkg::USER_RESET_VEC;
      next_r.swiVector = next_r.monitor ? swmp_pkg::MON_SWI_VEC
                                        : swmp_pkg::USER_SWI_VEC;

      unique case (r.st)
         swmp_pkg::ST_OFF: begin
         end
         swmp_pkg::ST_IDLE: begin
            if (r.pinPrev && !r.pinSync2) begin
               next_r.st = swmp_pkg::ST_RX;
               next_r.baudCnt = bitCyc >> 1;
               next_r.bitCnt = 4'h0;
            end
         end
         swmp_pkg::ST_RX: begin
            if (r.baudCnt != 16'h0000) begin
               next_r.baudCnt = r.baudCnt - 16'h0001;
            end else begin
               next_r.shift = {r.pinSync2, r.shift[9:1]};
               next_r.bitCnt = r.bitCnt + 4'h1;
               next_r.baudCnt = bitCyc;
               if (r.bitCnt == 4'h0 && r.pinSync2) begin
                  next_r.st = swmp_pkg::ST_IDLE;
               end else if (r.bitCnt == swmp_pkg::FRAME_LAST_BIT) begin
                  next_r.bitCnt = 4'h0;
                  if (!r.pinSync2 && next_r.shift[8:1] == 8'h00) begin
                     next_r.st = swmp_pkg::ST_BRK_HIGH;
                  end else begin
                     next_r.data = next_r.shift[8:1];
                     next_r.shift = {1'b1, next_r.shift[8:1], 1'b0};
                     next_r.st = swmp_pkg::ST_ECHO;
                  end
               end
            end
         end
         swmp_pkg::ST_BRK_HIGH: begin
            if (r.baudCnt != 16'h0000) begin
               next_r.baudCnt = r.baudCnt - 16'h0001;
            end else if (r.bitCnt == swmp_pkg::BREAK_HIGH_LAST) begin
               next_r.st = swmp_pkg::ST_BRK_TX;
               next_r.bitCnt = 4'h0;
               next_r.shift = 10'h000;
               next_r.baudCnt = bitCyc;
            end else begin
               next_r.bitCnt = r.bitCnt + 4'h1;
               next_r.baudCnt = bitCyc;
            end
         end
         swmp_pkg::ST_ECHO, swmp_pkg::ST_BRK_TX, swmp_pkg::ST_RESP: begin
            if (r.baudCnt != 16'h0000) begin
               next_r.baudCnt = r.baudCnt - 16'h0001;
            end else if (r.bitCnt != swmp_pkg::FRAME_LAST_BIT) begin
               next_r.bitCnt = r.bitCnt + 4'h1;
               next_r.shift = {r.shift[9], r.shift[9:1]};
               next_r.baudCnt = bitCyc;
            end else begin
               next_r.bitCnt = 4'h0;
               next_r.baudCnt = bitCyc;
               next_r.st = swmp_pkg::ST_IDLE;
               if (r.st == swmp_pkg::ST_RESP) begin
                  next_r.respLeft = r.respLeft - 2'h1;
                  if (next_r.respLeft != 2'h0) begin
                     next_r.addr = r.addr + 16'h0001;
                     next_r.st = (r.opcode == swmp_pkg::OP_STACK_POINTER_READ_CMD) ? swmp_pkg::ST_MEM_WAIT
                                                                    : swmp_pkg::ST_MEM_RD;
                  end
               end else if (r.st == swmp_pkg::ST_ECHO && !r.secDone) begin
                  next_r.secMatch = r.secMatch
                     && (r.data == securityCode[{r.secCnt[2:0], 3'b000} +: 8]);
                  next_r.secCnt = r.secCnt + 4'h1;
                  if (next_r.secCnt == swmp_pkg::SECURITY_BYTES) begin
                     next_r.secDone = 1'b1;
                     next_r.shift = 10'h000;
                     next_r.st = swmp_pkg::ST_BRK_TX;
                  end
               end else if (r.st == swmp_pkg::ST_ECHO && r.argIdx == 2'h0) begin
                  next_r.opcode = r.data;
                  case (r.data)
                     swmp_pkg::OP_READ, swmp_pkg::OP_WRITE, swmp_pkg::OP_INDEXED_WRITE_CMD: begin
                        next_r.argIdx = 2'h1;
                     end
                     swmp_pkg::OP_INDEXED_READ_CMD: begin
                        next_r.addr = r.lastAddr + 16'h0001;
                        next_r.respLeft = swmp_pkg::RESP_TWO;
                        next_r.st = swmp_pkg::ST_MEM_RD;
                     end
                     swmp_pkg::OP_STACK_POINTER_READ_CMD: begin
                        next_r.respLeft = swmp_pkg::RESP_TWO;
                        next_r.st = swmp_pkg::ST_MEM_WAIT;
                     end
                     swmp_pkg::OP_RUN: begin
                        next_r.runUser = 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end else if (r.st == swmp_pkg::ST_ECHO) begin
                  next_r.argIdx = r.argIdx + 2'h1;
                  if (r.opcode == swmp_pkg::OP_INDEXED_WRITE_CMD) begin
                     next_r.addr = r.lastAddr + 16'h0001;
                     next_r.argIdx = 2'h0;
                     next_r.st = swmp_pkg::ST_MEM_WR;
                  end else if (r.argIdx == 2'h1) begin
                     next_r.addr[15:8] = r.data;
                  end else if (r.argIdx == 2'h2) begin
                     next_r.addr[7:0] = r.data;
                     if (r.opcode == swmp_pkg::OP_READ) begin
                        next_r.respLeft = 2'h1;
                        next_r.argIdx = 2'h0;
                        next_r.st = swmp_pkg::ST_MEM_RD;
                     end
                  end else begin
                     next_r.argIdx = 2'h0;
                     next_r.st = swmp_pkg::ST_MEM_WR;
                  end
               end
            end
         end
         swmp_pkg::ST_MEM_RD: begin
            next_r.mem.req = 1'b1;
            next_r.mem.addr = r.addr;
            next_r.bitCnt = 4'h0;
            next_r.st = swmp_pkg::ST_MEM_WAIT;
         end
         swmp_pkg::ST_MEM_WAIT: begin
            if (r.bitCnt == 4'h0) begin
               next_r.bitCnt = 4'h1;
            end else begin
               if (r.opcode == swmp_pkg::OP_STACK_POINTER_READ_CMD) begin
                  respByte = (r.respLeft == swmp_pkg::RESP_TWO) ? stackPointer[15:8]
                                                                : stackPointer[7:0];
               end else begin
                  respByte = (!(r.secDone && r.secMatch) && r.addr >= FlashBase)
                             ? swmp_pkg::INVALID_BYTE : memRdata;
                  next_r.lastAddr = r.addr;
               end
               next_r.shift = {1'b1, respByte, 1'b0};
               next_r.bitCnt = 4'h0;
               next_r.baudCnt = bitCyc;
               next_r.st = swmp_pkg::ST_RESP;
            end
         end
         swmp_pkg::ST_MEM_WR: begin
            next_r.mem.req = 1'b1;
            next_r.mem.we = 1'b1;
            next_r.mem.addr = r.addr;
            next_r.mem.wdata = r.data;
            next_r.lastAddr = r.addr;
            next_r.st = swmp_pkg::ST_IDLE;
         end
         default: begin
            next_r.st = swmp_pkg::ST_IDLE;
         end
      endcase

      next_r.pinOe = (next_r.st == swmp_pkg::ST_ECHO || next_r.st == swmp_pkg::ST_BRK_TX
                      || next_r.st == swmp_pkg::ST_RESP) && !next_r.shift[0];
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs
   assign serialOut = 1'b0;
   assign serialOe = r.pinOe;
   assign memReq = r.mem;
   assign monitorMode = r.monitor;
   assign clockBypass = r.clockBypass;
   assign baudFast = r.clockBypass;
   assign watchdogEnable = r.watchdogEnable;
   assign resetVector = r.resetVector;
   assign swiVector = r.swiVector;
   assign flashUnlocked = r.secDone && r.secMatch;
   assign runUser = r.runUser;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_wdog;
      r.monitor && (r.strapSync2.irqHighVolt || r.strapSync2.rstHighVolt) |=> !r.watchdogEnable;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog enabled under high voltage");

   property p_vector;
      r.captured && $stable(r.monitor) |-> r.resetVector == (r.monitor
         ? swmp_pkg::MON_RESET_VEC : swmp_pkg::USER_RESET_VEC);
   endproperty
   a_vector: assert property (p_vector) else $error("reset vector wrong for mode");

   property p_bypass;
      r.clockBypass |-> r.monitor && baudFast;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass outside monitor mode");

   property p_drive;
      (r.st == swmp_pkg::ST_ECHO || r.st == swmp_pkg::ST_RESP) |-> serialOe == !r.shift[0];
   endproperty
   a_drive: assert property (p_drive) else $error("pin drive differs from shifter");

   property p_brkhigh;
      r.st == swmp_pkg::ST_BRK_HIGH |-> !serialOe ##1 (!serialOe || r.st == swmp_pkg::ST_BRK_TX);
   endproperty
   a_brkhigh: assert property (p_brkhigh) else $error("pin pulled during break gap");

   property p_break;
      $past(r.st) == swmp_pkg::ST_RX && r.st == swmp_pkg::ST_BRK_HIGH |-> r.shift == 10'h000;
   endproperty
   a_break: assert property (p_break) else $error("break taken on nonzero frame");

   property p_secure;
      r.st == swmp_pkg::ST_MEM_RD || r.st == swmp_pkg::ST_MEM_WR |-> r.secDone;
   endproperty
   a_secure: assert property (p_secure) else $error("command before security bytes");

   property p_indexed_read_cmd;
      $past(r.st) == swmp_pkg::ST_ECHO && r.st == swmp_pkg::ST_MEM_RD
      && r.opcode == swmp_pkg::OP_INDEXED_READ_CMD |-> r.addr == r.lastAddr + 16'h0001;
   endproperty
   a_indexed_read_cmd: assert property (p_indexed_read_cmd) else $error("indexed read address wrong");

   property p_indexed_write_cmd;
      r.st == swmp_pkg::ST_MEM_WR && r.opcode == swmp_pkg::OP_INDEXED_WRITE_CMD
      |-> r.addr == r.lastAddr + 16'h0001 ##1 memReq.req && memReq.we;
   endproperty
   a_indexed_write_cmd: assert property (p_indexed_write_cmd) else $error("indexed write address wrong");

   property p_run;
      runUser |-> r.opcode == swmp_pkg::OP_RUN && $past(r.st) == swmp_pkg::ST_ECHO;
   endproperty
   a_run: assert property (p_run) else $error("run pulse without run opcode");

   property p_result;
      $rose(r.st == swmp_pkg::ST_RESP) |-> $past(r.st) == swmp_pkg::ST_MEM_WAIT;
   endproperty
   a_result: assert property (p_result) else $error("result not after echo and fetch");

endmodule

// File: design/swmp_pkg.sv
package swmp_pkg;

   // clock and serial timing
   localparam int CLOCK_HZ        = 125_000_000;
   localparam int BAUD_SLOW       = 4800;
   localparam int BAUD_FAST       = 9600;
   localparam int BIT_CYCLES_SLOW = CLOCK_HZ / BAUD_SLOW;
   localparam int BIT_CYCLES_FAST = CLOCK_HZ / BAUD_FAST;

   // frame and sequence counts
   localparam logic [3:0] FRAME_LAST_BIT  = 4'h9;
   localparam logic [3:0] BREAK_HIGH_LAST = 4'h1;
   localparam logic [3:0] SECURITY_BYTES  = 4'h8;
   localparam logic [1:0] SETTLE_LAST     = 2'h3;
   localparam logic [1:0] RESP_TWO        = 2'h2;

   // command opcodes
   localparam logic [7:0] OP_READ   = 8'h4a;
   localparam logic [7:0] OP_WRITE  = 8'h49;
   localparam logic [7:0] OP_INDEXED_READ_CMD  = 8'h1a;
   localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h19;
   localparam logic [7:0] OP_STACK_POINTER_READ_CMD = 8'h0c;
   localparam logic [7:0] OP_RUN    = 8'h28;

   // vectors and memory
   localparam logic [15:0] USER_RESET_VEC = 16'hfffe;
   localparam logic [15:0] USER_SWI_VEC   = 16'hfffc;
   localparam logic [15:0] MON_RESET_VEC  = 16'hfefe;
   localparam logic [15:0] MON_SWI_VEC    = 16'hfefc;
   localparam logic [15:0] FLASH_BASE     = 16'h8000;
   localparam logic [7:0]  INVALID_BYTE   = 8'hff;

   typedef enum logic [3:0] {
      ST_OFF, ST_IDLE, ST_RX, ST_ECHO, ST_BRK_HIGH, ST_BRK_TX,
      ST_MEM_RD, ST_MEM_WAIT, ST_MEM_WR, ST_RESP
   } swmp_state_t;

   typedef struct packed {
      logic irqHighVolt;
      logic rstHighVolt;
      logic entryStrapHigh;
      logic entryStrapLow;
      logic clockSelectStrap;
   } swmp_straps_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } swmp_mem_req_t;

   typedef struct packed {
      swmp_state_t   st;
      logic [15:0]   baudCnt;
      logic [3:0]    bitCnt;
      logic [9:0]    shift;
      logic          pinSync1;
      logic          pinSync2;
      logic          pinPrev;
      swmp_straps_t  strapSync1;
      swmp_straps_t  strapSync2;
      logic [1:0]    settle;
      logic          captured;
      logic          monitor;
      logic          clockBypass;
      logic          watchdogEnable;
      logic [15:0]   resetVector;
      logic [15:0]   swiVector;
      logic [3:0]    secCnt;
      logic          secDone;
      logic          secMatch;
      logic [7:0]    opcode;
      logic [1:0]    argIdx;
      logic [15:0]   addr;
      logic [15:0]   lastAddr;
      logic [7:0]    data;
      logic [1:0]    respLeft;
      logic          runUser;
      logic          pinOe;
      swmp_mem_req_t mem;
   } swmp_regs_t;

endpackage

// File: testbench/swmp_host_model.sv
module swmp_host_model (
   // clock
   input  wire logic       clock,
   // wired-or serial line
   input  wire logic       serialWire,
   output logic            pullLow,
   // bit time in clock cycles
   input  wire logic [7:0] bitCycles
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [8:0] rxQ[$];
   logic [8:0] rx;
   logic       txBusy   = 1'b0;
   logic       prevWire = 1'b1;

   initial pullLow = 1'b0;

   // host frame lsb first; all zero bits make a break
   task automatic sendFrame(input logic [9:0] bits);
      for (int i = 0; i < 10; i++) begin
         txBusy = (i < 9);
         pullLow <= !bits[i];
         repeat (bitCycles) @(posedge clock);
      end
      pullLow <= 1'b0;
   endtask

   // receiver: bit 8 of a queue entry flags a low stop bit
   initial forever begin
      @(posedge clock);
      if (!txBusy && prevWire && !serialWire) begin
         repeat (bitCycles / 2) @(posedge clock);
         if (!serialWire) begin
            for (int i = 0; i < 8; i++) begin
               repeat (bitCycles) @(posedge clock);
               rx[i] = serialWire;
            end
            repeat (bitCycles) @(posedge clock);
            rx[8] = !serialWire;
            // hand over at frame end so a frame right behind it is still seen
            while (!serialWire) @(posedge clock);
            repeat (bitCycles / 2 - 1) @(posedge clock);
            rxQ.push_back(rx);
         end
      end
      prevWire = serialWire;
   end
endmodule

// File: testbench/swmp_monitor_port_tb_top.sv
module swmp_monitor_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int FastBits = 8;
   localparam int SlowBits = 16;

   logic                    clock        = 1'b0;
   logic                    rst_n        = 1'b0;
   logic                    serialWire;
   logic                    serialOut;
   logic                    serialOe;
   logic                    hostPull;
   swmp_pkg::swmp_straps_t  straps       = 5'h14;
   logic                    swiExec      = 1'b0;
   logic [15:0]             stackPointer = 16'h00ff;
   logic [63:0]             securityCode = 64'h0123456789abcdef;
   swmp_pkg::swmp_mem_req_t memReq;
   logic [7:0]              memRdata     = 8'h00;
   logic                    monitorMode;
   logic                    clockBypass;
   logic                    baudFast;
   logic                    watchdogEnable;
   logic [15:0]             resetVector;
   logic [15:0]             swiVector;
   logic                    flashUnlocked;
   logic                    runUser;
   logic [7:0]              bitCycles    = 8'h08;
   logic [7:0]              mem [0:65535];
   int                      errTotal     = 0;
   int                      nTests       = 0;
   int                      cycles       = 0;
   int                      runCnt       = 0;

   always #4 clock = ~clock;
   assign serialWire = !(serialOe && !serialOut) && !hostPull;

   swmp_monitor_port #(.BitCyclesSlow(SlowBits), .BitCyclesFast(FastBits)) u_swmp_monitor_port (
      .clock(clock), .rst_n(rst_n), .serialIn(serialWire), .serialOut(serialOut),
      .serialOe(serialOe), .straps(straps), .swiExec(swiExec), .stackPointer(stackPointer),
      .securityCode(securityCode), .memReq(memReq), .memRdata(memRdata),
      .monitorMode(monitorMode), .clockBypass(clockBypass), .baudFast(baudFast),
      .watchdogEnable(watchdogEnable), .resetVector(resetVector), .swiVector(swiVector),
      .flashUnlocked(flashUnlocked), .runUser(runUser));

   swmp_host_model u_swmp_host_model (
      .clock(clock), .serialWire(serialWire), .pullLow(hostPull), .bitCycles(bitCycles));

   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction

   initial for (int i = 0; i < 65536; i++) mem[i] = pat(16'(i));

   // memory with one-cycle read latency
   always @(posedge clock) begin
      if (memReq.req) begin
         if (memReq.we) mem[memReq.addr] <= memReq.wdata;
         memRdata <= mem[memReq.addr];
      end
      if (runUser === 1'b1) runCnt++;
      cycles++;
      if (cycles == 40000) begin
         errTotal++;
         $display("[FAIL] %0t run did not finish", $time);
         completeRun();
      end
   end

   task automatic waitCyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chkRx(input logic [8:0] exp);
      logic [8:0] got;
      int         n;
      got = 'x;
      n = 0;
      while (u_swmp_host_model.rxQ.size() == 0 && n < 4000) begin
         @(posedge clock);
         n++;
      end
      if (u_swmp_host_model.rxQ.size() > 0) got = u_swmp_host_model.rxQ.pop_front();
      nTests++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] %0t serial got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
      nTests++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chkFlag(input logic got, input logic exp, input string what);
      nTests++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] b);
      u_swmp_host_model.sendFrame({1'b1, b, 1'b0});
      chkRx({1'b0, b});
   endtask

   task automatic doReset(input logic hv, input logic clkStrap, input logic [7:0] bits);
      rst_n <= 1'b0;
      straps <= {hv, 1'b0, 1'b1, 1'b0, clkStrap};
      bitCycles <= bits;
      waitCyc(12);
      rst_n <= 1'b1;
      waitCyc(8);
   endtask

   task automatic secure(input logic [63:0] code, input logic unlock);
      for (int k = 0; k < 8; k++) xfer(code[8*k +: 8]);
      chkRx(9'h100);
      chkFlag(flashUnlocked, unlock, "unlocked");
   endtask

   task automatic readAt(input logic [15:0] a, input logic [7:0] exp);
      xfer(8'h4a);
      xfer(a[15:8]);
      xfer(a[7:0]);
      chkRx({1'b0, exp});
   endtask

   task automatic testSwiEntry;
      doReset(1'b0, 1'b0, 8'(FastBits));
      chkFlag(monitorMode, 1'b0, "user mode");
      chkWord(resetVector, 16'hfffe, "user reset vector");
      chkWord(swiVector, 16'hfffc, "user swi vector");
      chkFlag(watchdogEnable, 1'b1, "user watchdog");
      swiExec <= 1'b1;
      waitCyc(1);
      swiExec <= 1'b0;
      waitCyc(4);
      chkFlag(monitorMode, 1'b1, "swi entry");
      chkWord(swiVector, 16'hfefc, "monitor swi vector");
      $display("test swi entry done");
   endtask

   task automatic testEntryFast;
      doReset(1'b1, 1'b0, 8'(FastBits));
      chkFlag(monitorMode, 1'b1, "monitor mode");
      chkFlag(clockBypass, 1'b1, "bypass");
      chkFlag(baudFast, 1'b1, "fast rate");
      chkFlag(watchdogEnable, 1'b0, "watchdog off");
      chkWord(resetVector, 16'hfefe, "monitor reset vector");
      chkWord(swiVector, 16'hfefc, "monitor swi vector");
      secure(securityCode, 1'b1);
      $display("test fast entry done");
   endtask

   task automatic testCommands;
      int n;
      readAt(16'hffff, pat(16'hffff));
      readAt(16'h8010, pat(16'h8010));
      xfer(8'h1a);
      chkRx({1'b0, pat(16'h8011)});
      chkRx({1'b0, pat(16'h8012)});
      xfer(8'h19);
      xfer(8'h3c);
      waitCyc(4);
      chkWord({8'h00, mem[16'h8013]}, 16'h003c, "indexed write");
      xfer(8'h49);
      xfer(8'h00);
      xfer(8'h80);
      xfer(8'ha5);
      waitCyc(4);
      chkWord({8'h00, mem[16'h0080]}, 16'h00a5, "write");
      xfer(8'h0c);
      chkRx(9'h000);
      chkRx(9'h0ff);
      n = runCnt;
      xfer(8'h28);
      waitCyc(4);
      chkWord(16'(runCnt - n), 16'h0001, "run pulses");
      $display("test commands done");
   endtask

   task automatic testBreak;
      int gap;
      gap = 0;
      u_swmp_host_model.sendFrame(10'h000);
      @(posedge clock);
      while (serialWire && gap < 200) begin
         @(posedge clock);
         gap++;
      end
      chkFlag(gap >= 2 * FastBits - 2 && gap <= 2 * FastBits + 2, 1'b1, "break gap");
      chkRx(9'h100);
      $display("test break done");
   endtask

   task automatic testSlow;
      straps <= 5'h0c;
      waitCyc(8);
      chkFlag(watchdogEnable, 1'b0, "watchdog off by reset pin voltage");
      straps.rstHighVolt <= 1'b0;
      waitCyc(8);
      chkFlag(watchdogEnable, 1'b1, "watchdog back");
      doReset(1'b1, 1'b1, 8'(SlowBits));
      chkFlag(baudFast, 1'b0, "slow rate");
      chkFlag(clockBypass, 1'b0, "no bypass");
      secure(securityCode ^ 64'h1, 1'b0);
      readAt(16'h8010, swmp_pkg::INVALID_BYTE);
      readAt(16'h0040, pat(16'h0040));
      $display("test slow entry done");
   endtask

   task automatic completeRun;
      $display("comparisons %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      testSwiEntry();
      testEntryFast();
      testCommands();
      testBreak();
      testSlow();
      completeRun();
   end
endmodule
